// file: core/axis_counters_pkg.sv
// constants, types and helpers shared by the axis counter set
package axis_counters_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD_POS = 8'h00;
  localparam logic [7:0] ADDR_FB_POS = 8'h04;
  localparam logic [7:0] ADDR_DEVIATION = 8'h08;
  localparam logic [7:0] ADDR_GP_CNT = 8'h0C;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SRC_BIT = 2;
  localparam int CFG_IDXPOL_BIT = 3;
  localparam int CFG_GP_LSB = 4;
  localparam int CFG_W = 6;
  localparam int CTRL_DEV_CLR_BIT = 0;
  localparam int STAT_INDEX_BIT = 0;
  localparam int STAT_PHA_BIT = 1;
  localparam int STAT_PHB_BIT = 2;
  localparam logic [31:0] CNT_RESET = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;
  localparam logic [31:0] CNT_MINUS_ONE = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    FB_UP_DOWN,
    FB_QUAD_1X,
    FB_QUAD_2X,
    FB_QUAD_4X
  } fb_mode_e;

  typedef enum logic [1:0] {
    GP_SRC_OUT,
    GP_SRC_FB,
    GP_SRC_MPG,
    GP_SRC_CLK2
  } gp_src_e;

  typedef struct packed {
    gp_src_e gp_src;
    logic index_pol;
    logic fb_src;
    fb_mode_e fb_mode;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{gp_src: GP_SRC_MPG, index_pol: 1'b0,
                                 fb_src: 1'b0, fb_mode: FB_UP_DOWN};

  typedef struct packed {
    logic step;
    logic up;
  } step_s;

  function automatic logic [31:0] step_delta(input step_s s);
    step_delta = !s.step ? CNT_RESET : (s.up ? CNT_ONE : CNT_MINUS_ONE);
  endfunction : step_delta
endpackage : axis_counters_pkg

// file: core/sync_2ff.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule : sync_2ff
`default_nettype wire

// file: core/quad_step_decoder.sv
// turns two synchronised phase levels into signed count steps
`timescale 1ns/100ps
`default_nettype none
module quad_step_decoder
  import axis_counters_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire fb_mode_e mode,
  output step_s step_out
);
  logic a_prev_reg;
  logic b_prev_reg;
  step_s step_next;

  always_comb begin
    logic a_chg;
    logic b_chg;
    a_chg = phase_a ^ a_prev_reg;
    b_chg = phase_b ^ b_prev_reg;
    step_next = '{step: 1'b0, up: 1'b0};
    case (mode)
      FB_UP_DOWN: begin
        // both rising together cancel out
        if (a_chg && phase_a && !(b_chg && phase_b)) begin
          step_next = '{step: 1'b1, up: 1'b1};
        end else if (b_chg && phase_b && !(a_chg && phase_a)) begin
          step_next = '{step: 1'b1, up: 1'b0};
        end
      end
      FB_QUAD_1X: begin
        if (a_chg && !b_chg && !phase_b) begin
          step_next = '{step: 1'b1, up: phase_a};
        end
      end
      FB_QUAD_2X: begin
        if (a_chg && !b_chg) begin
          step_next = '{step: 1'b1, up: phase_a ^ phase_b};
        end
      end
      default: begin
        // a double change is a skipped state and is dropped
        if (a_chg ^ b_chg) begin
          step_next = '{step: 1'b1, up: phase_a ^ b_prev_reg};
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      step_out <= '{step: 1'b0, up: 1'b0};
    end else begin
      a_prev_reg <= phase_a;
      b_prev_reg <= phase_b;
      step_out <= step_next;
    end
  end
endmodule : quad_step_decoder
`default_nettype wire

// file: core/axis_position_counters.sv
// per-axis position counters with an APB register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module axis_position_counters
  import axis_counters_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic out_pulse,
  input wire logic out_dir_up,
  input wire logic home_done,
  input wire logic encoder_phase_first,
  input wire logic encoder_phase_second,
  input wire logic encoder_index,
  input wire logic mpg_phase_a,
  input wire logic mpg_phase_b,
  output logic index_active
);
  logic [4:0] pins_sync;
  logic enc_a_s;
  logic enc_b_s;
  logic enc_z_s;
  logic mpg_a_s;
  logic mpg_b_s;
  step_s enc_step;
  step_s mpg_step;
  step_s cmd_step;
  step_s fb_step;
  step_s gp_step;
  cfg_s cfg_reg;
  logic [DATA_W-1:0] cmd_pos_reg;
  logic [DATA_W-1:0] fb_pos_reg;
  logic [DATA_W-1:0] dev_reg;
  logic [DATA_W-1:0] gp_cnt_reg;
  logic clk2_en_reg;
  logic access;
  logic fire;
  logic wr_fire;
  logic rd_fire;
  logic cmd_wr;
  logic fb_wr;
  logic gp_wr;
  logic cfg_wr;
  logic dev_clr;
  logic [DATA_W-1:0] rdata_next;
  logic addr_ok;

  sync_2ff #(
    .W(5)
  ) u_pin_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in({mpg_phase_b, mpg_phase_a, encoder_index,
               encoder_phase_second, encoder_phase_first}),
    .sync_out(pins_sync)
  );

  assign enc_a_s = pins_sync[0];
  assign enc_b_s = pins_sync[1];
  assign enc_z_s = pins_sync[2];
  assign mpg_a_s = pins_sync[3];
  assign mpg_b_s = pins_sync[4];

  quad_step_decoder u_enc_dec (
    .mclk(mclk),
    .resetn(resetn),
    .phase_a(enc_a_s),
    .phase_b(enc_b_s),
    .mode(cfg_reg.fb_mode),
    .step_out(enc_step)
  );

  // the hand pulser is always read as single-edge quadrature
  quad_step_decoder u_mpg_dec (
    .mclk(mclk),
    .resetn(resetn),
    .phase_a(mpg_a_s),
    .phase_b(mpg_b_s),
    .mode(FB_QUAD_1X),
    .step_out(mpg_step)
  );

  // apb: one wait state so every answer leaves a flip-flop
  assign access = psel && penable;
  assign fire = access && pready;
  assign wr_fire = fire && pwrite;
  assign rd_fire = fire && !pwrite;
  assign cmd_wr = wr_fire && paddr == ADDR_CMD_POS;
  assign fb_wr = wr_fire && paddr == ADDR_FB_POS;
  assign gp_wr = wr_fire && paddr == ADDR_GP_CNT;
  assign cfg_wr = wr_fire && paddr == ADDR_CONFIG;
  assign dev_clr = wr_fire && paddr == ADDR_CONTROL
                   && pwdata[CTRL_DEV_CLR_BIT];

  always_comb begin
    addr_ok = 1'b1;
    rdata_next = CNT_RESET;
    case (paddr)
      ADDR_CMD_POS: rdata_next = cmd_pos_reg;
      ADDR_FB_POS: rdata_next = fb_pos_reg;
      ADDR_DEVIATION: rdata_next = dev_reg;
      ADDR_GP_CNT: rdata_next = gp_cnt_reg;
      ADDR_CONFIG: rdata_next = {{(DATA_W - CFG_W){1'b0}}, cfg_reg};
      ADDR_CONTROL: rdata_next = CNT_RESET;
      ADDR_STATUS: begin
        rdata_next[STAT_INDEX_BIT] = index_active;
        rdata_next[STAT_PHA_BIT] = enc_a_s;
        rdata_next[STAT_PHB_BIT] = enc_b_s;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= CNT_RESET;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      if (access && !pready && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= cfg_s'(pwdata[CFG_W-1:0]);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      index_active <= 1'b0;
    end else begin
      index_active <= enc_z_s ^ cfg_reg.index_pol;
    end
  end

  // divide-by-two enable standing in for clk/2
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk2_en_reg <= 1'b0;
    end else begin
      clk2_en_reg <= !clk2_en_reg;
    end
  end

  assign cmd_step = '{step: out_pulse, up: out_dir_up};
  assign fb_step = cfg_reg.fb_src ? cmd_step : enc_step;

  always_comb begin
    case (cfg_reg.gp_src)
      GP_SRC_OUT: gp_step = cmd_step;
      GP_SRC_FB: gp_step = fb_step;
      GP_SRC_MPG: gp_step = mpg_step;
      default: gp_step = '{step: clk2_en_reg, up: 1'b1};
    endcase
  end

  // home clear beats host load, host load beats counting
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_pos_reg <= CNT_RESET;
    end else if (home_done) begin
      cmd_pos_reg <= CNT_RESET;
    end else if (cmd_wr) begin
      cmd_pos_reg <= pwdata;
    end else begin
      cmd_pos_reg <= cmd_pos_reg + step_delta(cmd_step);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fb_pos_reg <= CNT_RESET;
    end else if (home_done) begin
      fb_pos_reg <= CNT_RESET;
    end else if (fb_wr) begin
      fb_pos_reg <= pwdata;
    end else begin
      fb_pos_reg <= fb_pos_reg + step_delta(fb_step);
    end
  end

  // deviation always watches the encoder, whatever feeds fb_pos
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dev_reg <= CNT_RESET;
    end else if (home_done) begin
      dev_reg <= CNT_RESET;
    end else if (dev_clr) begin
      dev_reg <= CNT_RESET;
    end else begin
      dev_reg <= dev_reg + step_delta(cmd_step)
                 - step_delta(enc_step);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gp_cnt_reg <= CNT_RESET;
    end else if (gp_wr) begin
      gp_cnt_reg <= pwdata;
    end else begin
      gp_cnt_reg <= gp_cnt_reg + step_delta(gp_step);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // checks watch synchronised or decoded encoder and pulser signals, never their raw pins
  chk_home_clears_cmd: assert property (
    home_done |=> cmd_pos_reg == CNT_RESET)
    else $error("command counter not cleared by home");

  chk_home_clears_fb: assert property (
    home_done |=> fb_pos_reg == CNT_RESET)
    else $error("feedback counter not cleared by home");

  chk_home_clears_dev: assert property (
    home_done |=> dev_reg == CNT_RESET)
    else $error("deviation not cleared by home");

  // command counter: one step per pulse, frozen otherwise
  chk_cmd_count_dir: assert property (
    out_pulse && !home_done && !cmd_wr
    |=> cmd_pos_reg == $past(cmd_pos_reg)
        + ($past(out_dir_up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("command counter stepped wrongly");

  chk_cmd_idle_hold: assert property (
    !out_pulse && !home_done && !cmd_wr |=> $stable(cmd_pos_reg))
    else $error("command counter moved without a pulse");

  chk_cmd_host_load: assert property (
    cmd_wr && !home_done |=> cmd_pos_reg == $past(pwdata))
    else $error("command position load lost");

  chk_fb_host_load: assert property (
    fb_wr && !home_done |=> fb_pos_reg == $past(pwdata))
    else $error("feedback position load lost");

  chk_fb_enc_count: assert property (
    !cfg_reg.fb_src && enc_step.step && !home_done && !fb_wr
    |=> fb_pos_reg == $past(fb_pos_reg)
        + ($past(enc_step.up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("feedback counter missed an encoder step");

  chk_fb_out_source: assert property (
    cfg_reg.fb_src && out_pulse && !home_done && !fb_wr
    |=> fb_pos_reg == $past(fb_pos_reg)
        + ($past(out_dir_up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("feedback did not follow output pulses");

  // deviation: command steps add, encoder steps subtract
  chk_dev_cancel: assert property (
    out_pulse && enc_step.step && out_dir_up == enc_step.up
    && !home_done && !dev_clr |=> $stable(dev_reg))
    else $error("coinciding pulses moved deviation");

  chk_dev_cmd_only: assert property (
    out_pulse && !enc_step.step && !home_done && !dev_clr
    |=> dev_reg == $past(dev_reg)
        + ($past(out_dir_up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("deviation missed a command pulse");

  chk_dev_enc_only: assert property (
    !out_pulse && enc_step.step && !home_done && !dev_clr
    |=> dev_reg == $past(dev_reg)
        - ($past(enc_step.up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("deviation missed an encoder step");

  chk_dev_clear: assert property (
    dev_clr && !out_pulse |=> dev_reg == CNT_RESET
    ##1 dev_reg == $past(dev_reg) + step_delta($past(cmd_step))
        - step_delta($past(enc_step)))
    else $error("deviation clear or follow-up count wrong");

  // general counter: load, source select and clk/2 rate
  chk_gp_default_src: assert property (
    $rose(resetn) |-> cfg_reg.gp_src == GP_SRC_MPG)
    else $error("general counter source not pulser after reset");

  chk_gp_host_load: assert property (
    gp_wr |=> gp_cnt_reg == $past(pwdata))
    else $error("general counter load lost");

  chk_gp_out_source: assert property (
    cfg_reg.gp_src == GP_SRC_OUT && out_pulse && !gp_wr
    |=> gp_cnt_reg == $past(gp_cnt_reg)
        + ($past(out_dir_up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("general counter did not follow output pulses");

  chk_gp_fb_source: assert property (
    cfg_reg.gp_src == GP_SRC_FB && fb_step.step && !gp_wr
    |=> gp_cnt_reg == $past(gp_cnt_reg)
        + ($past(fb_step.up) ? CNT_ONE : CNT_MINUS_ONE))
    else $error("general counter did not follow feedback steps");

  chk_gp_clk2_rate: assert property (
    cfg_reg.gp_src == GP_SRC_CLK2 && !gp_wr && !cfg_wr ##1
    !gp_wr && !cfg_wr |=> gp_cnt_reg == $past(gp_cnt_reg, 2)
    + CNT_ONE)
    else $error("clk/2 source did not count once per two clocks");

  chk_cfg_write: assert property (
    cfg_wr |=> cfg_reg == $past(pwdata[CFG_W-1:0]))
    else $error("configuration write lost");

  chk_index_status: assert property (
    ##1 index_active == ($past(enc_z_s) ^ $past(cfg_reg.index_pol)))
    else $error("index status does not follow pin and polarity");

  // bus: one wait state, error only for unmapped offsets
  chk_apb_one_wait: assert property (
    access && !pready |=> pready ##1 !pready)
    else $error("apb answer not after exactly one wait");

  chk_apb_bad_addr: assert property (
    access && !pready && !addr_ok |=> pready && pslverr)
    else $error("unmapped offset answered without error");

  chk_apb_good_addr: assert property (
    access && !pready && addr_ok |=> pready && !pslverr)
    else $error("mapped offset answered with error");

  cov_home_done: cover property (out_pulse ##1 home_done);
  cov_dev_cancel: cover property (out_pulse && enc_step.step);
  cov_read_cmd: cover property (rd_fire && paddr == ADDR_CMD_POS);
  cov_quad_4x: cover property (
    cfg_reg.fb_mode == FB_QUAD_4X && enc_step.step && !enc_step.up);
  cov_clk2_count: cover property (
    cfg_reg.gp_src == GP_SRC_CLK2 && gp_step.step);
endmodule : axis_position_counters
`default_nettype wire

// file: tb/encoder_model.sv
// incremental encoder model: quadrature turns and up/down pulses
`timescale 1ns/100ps
`default_nettype none
module encoder_model (
  input wire logic mclk,
  output logic ph_first,
  output logic ph_second
);
  logic [1:0] pos = 2'h0;

  initial begin
    ph_first = 1'b0;
    ph_second = 1'b0;
  end

  // gray sequence, first phase leads when turning up
  task automatic turn(input int n, input bit up);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      pos = up ? pos + 2'h1 : pos - 2'h1;
      ph_first <= pos[1] ^ pos[0];
      ph_second <= pos[1];
    end
  endtask : turn

  // one pulse on a single line; only valid with both phases low
  task automatic pulse(input bit on_second);
    repeat (4) @(posedge mclk);
    if (on_second) ph_second <= 1'b1;
    else ph_first <= 1'b1;
    repeat (4) @(posedge mclk);
    ph_first <= 1'b0;
    ph_second <= 1'b0;
  endtask : pulse
endmodule : encoder_model
`default_nettype wire

// file: tb/test_axis_position_counters.sv
// self-checking bench for the axis counter set
`timescale 1ns/100ps
`default_nettype none
module test_axis_position_counters;
  import axis_counters_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic out_pulse = 1'b0;
  logic out_dir_up = 1'b0;
  logic home_done = 1'b0;
  logic encoder_index = 1'b0;
  logic enc_a, enc_b, mpg_a, mpg_b, index_active;
  logic last_err;
  logic [31:0] r;
  int bad_count = 0;
  int checks_done = 0;

  always #25 mclk = ~mclk;

  axis_position_counters i_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_pulse(out_pulse), .out_dir_up(out_dir_up), .home_done(home_done),
    .encoder_phase_first(enc_a), .encoder_phase_second(enc_b),
    .encoder_index(encoder_index), .mpg_phase_a(mpg_a),
    .mpg_phase_b(mpg_b), .index_active(index_active));
  encoder_model i_enc (.mclk(mclk), .ph_first(enc_a), .ph_second(enc_b));
  encoder_model i_mpg (.mclk(mclk), .ph_first(mpg_a), .ph_second(mpg_b));

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(r, exp);
  endtask : rd

  task automatic pulses(input int n, input bit up);
    repeat (n) begin
      @(posedge mclk);
      out_pulse <= 1'b1;
      out_dir_up <= up;
    end
    @(posedge mclk);
    out_pulse <= 1'b0;
  endtask : pulses

  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask : settle

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(ADDR_CONFIG, 32'h00000020);
    rd(ADDR_CMD_POS, 32'h00000000);
    rd(8'h1C, 32'h00000000);
    chk({31'h0, last_err}, 32'h00000001);
    pulses(3, 1'b1);
    pulses(1, 1'b0);
    rd(ADDR_CMD_POS, 32'h00000002);
    rd(ADDR_DEVIATION, 32'h00000002);
    rd(ADDR_FB_POS, 32'h00000000);
    wr(ADDR_CMD_POS, 32'hFFFFFFFF);
    pulses(1, 1'b1);
    rd(ADDR_CMD_POS, 32'h00000000);
    wr(ADDR_CONTROL, 32'h00000001);
    rd(ADDR_DEVIATION, 32'h00000000);
    repeat (3) i_enc.pulse(1'b0);
    i_enc.pulse(1'b1);
    settle();
    rd(ADDR_FB_POS, 32'h00000002);
    rd(ADDR_DEVIATION, 32'hFFFFFFFE);
    // encoder step lands inside a same-direction command burst
    fork
      pulses(12, 1'b1);
      i_enc.pulse(1'b0);
    join
    settle();
    rd(ADDR_DEVIATION, 32'h00000009);
    // multipliers 1x, 2x, 4x over one full encoder cycle each way
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_CONFIG, 32'h00000020 | m);
      wr(ADDR_FB_POS, 32'h00000000);
      i_enc.turn(4, 1'b1);
      settle();
      rd(ADDR_FB_POS, 32'h00000001 << (m - 1));
      i_enc.turn(4, 1'b0);
      settle();
      rd(ADDR_FB_POS, 32'h00000000);
    end
    wr(ADDR_CONFIG, 32'h00000024);
    wr(ADDR_FB_POS, 32'h00000000);
    pulses(2, 1'b1);
    rd(ADDR_FB_POS, 32'h00000002);
    wr(ADDR_GP_CNT, 32'h00000005);
    @(posedge mclk);
    home_done <= 1'b1;
    @(posedge mclk);
    home_done <= 1'b0;
    rd(ADDR_CMD_POS, 32'h00000000);
    rd(ADDR_FB_POS, 32'h00000000);
    rd(ADDR_DEVIATION, 32'h00000000);
    rd(ADDR_GP_CNT, 32'h00000005);
    wr(ADDR_CONFIG, 32'h00000000);
    pulses(3, 1'b1);
    pulses(1, 1'b0);
    rd(ADDR_GP_CNT, 32'h00000007);
    wr(ADDR_CONFIG, 32'h00000010);
    i_enc.pulse(1'b0);
    settle();
    rd(ADDR_GP_CNT, 32'h00000008);
    wr(ADDR_CONFIG, 32'h00000020);
    i_mpg.turn(4, 1'b1);
    settle();
    rd(ADDR_GP_CNT, 32'h00000009);
    // clk/2 stands for four edges between the writes: two counts
    wr(ADDR_CONFIG, 32'h00000030);
    wr(ADDR_CONFIG, 32'h00000020);
    rd(ADDR_GP_CNT, 32'h0000000B);
    encoder_index <= 1'b1;
    settle();
    rd(ADDR_STATUS, 32'h00000001);
    chk({31'h0, index_active}, 32'h00000001);
    wr(ADDR_CONFIG, 32'h00000028);
    settle();
    rd(ADDR_STATUS, 32'h00000000);
    chk({31'h0, index_active}, 32'h00000000);
    final_report();
  end
endmodule : test_axis_position_counters
`default_nettype wire
